// >>> design/isa_mode_switch.sv
// instruction-set mode switch: mode bits, transfer targets, faults, ahb registers
// How it works
// RULE1 - one selector bit: 1 legacy, 0 native
// RULE2 - any interruption clears the selector
// RULE3 - return-from-interruption restores either instruction set
// RULE4 - native mode: no segment checks or base
// RULE5 - native mode: full 64-bit addresses, all translated
// RULE6 - legacy mode: addresses confined to low 4G
// RULE7 - legacy mode forces little-endian references
// RULE8 - legacy system-resource access raises interception fault
// RULE9 - legacy mode hides native-only register state
// RULE10 - disable bit turns transfers into faults
// RULE11 - return and interruption ignore disable bit
// RULE12 - absolute native jump: disp plus base
// RULE13 - indirect native jump: register plus base
// RULE14 - native jump target 16-byte aligned, low 4G
// RULE15 - pending legacy numeric exception nullifies native jump
// RULE16 - privilege level unchanged by any transfer
// RULE17 - branch-to-legacy: pointer from branch register, minus base
// RULE18 - limit or privilege violation gives protection fault
// RULE19 - software hints branch-to-legacy static taken
// RULE20 - software flushes register stack before legacy
// RULE21 - legacy fetch need not see native stores
// RULE22 - software loads code segment before branching
// RULE23 - selector and new pointer update together
`timescale 1ns/1ps
`default_nettype none
`include "isa_mode_defines.svh"
module isa_mode_switch (
   input  wire logic                    CLK_IN,            // core clock, 40 MHz
   input  wire logic                    RST_B_IN,          // async reset, active low
   // ahb-lite slave
   input  wire logic                    HSEL_IN,
   input  wire logic [7:0]              HADDR_IN,
   input  wire logic [1:0]              HTRANS_IN,
   input  wire logic                    HWRITE_IN,
   input  wire logic [2:0]              HSIZE_IN,
   input  wire logic [31:0]             HWDATA_IN,
   input  wire logic                    HREADY_IN,
   output logic [31:0]                  HRDATA_OUT,
   output logic                         HREADYOUT_OUT,
   output logic                         HRESP_OUT,
   // front-end request port
   input  wire logic                    REQ_VALID_IN,      // one-cycle request strobe
   input  wire isa_mode_pkg::req_kind_t REQ_KIND_IN,       // which transfer
   input  wire logic                    REQ_OPSIZE32_IN,   // native jump operand size
   input  wire logic [31:0]             REQ_OPERAND_IN,    // disp or register value
   input  wire logic [31:0]             REQ_SRC_BRANCH_IN, // low half of source branch reg
   input  wire logic [63:0]             REQ_RESUME_IP_IN,  // pointer restored by return
   input  wire logic                    REQ_RESUME_SEL_IN, // selector restored by return
   input  wire logic [63:0]             REQ_VECTOR_IN,     // interruption vector pointer
   input  wire logic                    FP_PENDING_IN,     // legacy numeric exception pending
   input  wire logic                    CS_PRIV_FAIL_IN,   // code segment privilege violation
   input  wire logic                    SYS_ACCESS_IN,     // legacy access to system resource
   // outputs to the core
   output logic                         INSTR_SET_SELECT_OUT,
   output logic                         REDIRECT_OUT,      // one-cycle pointer load pulse
   output logic [63:0]                  TARGET_IP_OUT,
   output logic [31:0]                  LEGACY_INSTR_POINTER_OUT,
   output logic                         FAULT_OUT,         // fault pulse, one cycle per request; stays high while a legacy system access is held
   output isa_mode_pkg::fault_kind_t    FAULT_KIND_OUT,
   output logic [15:0]                  FAULT_CODE_OUT,
   output logic                         SEG_ENABLE_OUT,    // segmentation in effect
   output logic                         ADDR_LIMIT4G_OUT,  // confine to low 4G of region 0
   output logic                         FORCE_LE_OUT,      // force little-endian
   output logic                         HIDE_NATIVE_OUT,   // hide native-only registers
   output logic [1:0]                   PRIV_LEVEL_OUT
);
   import isa_mode_pkg::*;

   logic        instr_set_select;    // current instruction set
   logic        transition_disable;  // blocks the two user transfers
   logic [1:0]  priv_level;          // software-written privilege level
   logic [31:0] code_segment_base;   // code segment base
   logic [31:0] cs_limit;            // code segment limit
   logic [63:0] last_target;         // last loaded pointer
   logic [31:0] legacy_instr_pointer;// last legacy pointer
   fault_kind_t last_fault;          // last fault seen
   // synchronised external levels
   logic fp_meta, fp_sync;           // pending numeric exception
   logic pv_meta, pv_sync;           // privilege violation
   logic sa_meta, sa_sync;           // system resource access
   // ahb data phase capture
   logic        dp_valid;            // data phase pending
   logic        dp_write;            // pending phase is a write
   logic [7:0]  dp_addr;             // pending address
   // decode of the request this cycle
   logic        next_redirect;
   logic [63:0] next_target;
   logic        next_select;
   logic [31:0] next_legacy_ip;
   fault_kind_t next_fault;
   logic        do_jmp, do_br;

   target_if tgt ();

   // arithmetic kept apart so the controller stays a pure sequencer
   target_calc u_calc (
      .use_reg_in    (REQ_KIND_IN == REQ_JMP_NATIVE_REG),
      .opsize32_in   (REQ_OPSIZE32_IN),
      .disp_in       (REQ_OPERAND_IN),
      .reg_val_in    (REQ_OPERAND_IN),
      .src_branch_in (REQ_SRC_BRANCH_IN),
      .cs_base_in    (code_segment_base),
      .cs_limit_in   (cs_limit),
      .tgt           (tgt)
   );

   // status and fault lines are outside core timing, so two flops each
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         fp_meta <= 1'b0;
         fp_sync <= 1'b0;
         pv_meta <= 1'b0;
         pv_sync <= 1'b0;
         sa_meta <= 1'b0;
         sa_sync <= 1'b0;
      end else begin
         fp_meta <= FP_PENDING_IN;
         fp_sync <= fp_meta;
         pv_meta <= CS_PRIV_FAIL_IN;
         pv_sync <= pv_meta;
         sa_meta <= SYS_ACCESS_IN;
         sa_sync <= sa_meta;
      end
   end

   // is the access a selected active transfer with ready high in the address phase; size is not checked
   function automatic logic addr_phase(input logic sel, input logic [1:0] trans, input logic rdy);
      addr_phase = sel && trans[1] && rdy;
   endfunction

   // request decode; the pointer and selector leave in the same flop stage
   always_comb begin
      next_redirect  = 1'b0;
      next_target    = last_target;
      next_select    = instr_set_select;
      next_legacy_ip = legacy_instr_pointer;
      next_fault     = FLT_NONE;
      do_jmp = REQ_VALID_IN && instr_set_select &&
               (REQ_KIND_IN == REQ_JMP_NATIVE_ABS || REQ_KIND_IN == REQ_JMP_NATIVE_REG);
      do_br  = REQ_VALID_IN && !instr_set_select && (REQ_KIND_IN == REQ_BR_LEGACY);
      if (REQ_VALID_IN && REQ_KIND_IN == REQ_INTERRUPT) begin
         // every interruption lands in native, disable bit ignored
         next_redirect = 1'b1; // RULE2 RULE11
         next_target   = REQ_VECTOR_IN;
         next_select   = 1'b0; // RULE2
      end else if (REQ_VALID_IN && REQ_KIND_IN == REQ_RETURN_INTR) begin
         // restored state chooses the set, disable bit ignored
         next_redirect = 1'b1; // RULE3 RULE11
         next_target   = REQ_RESUME_IP_IN;
         next_select   = REQ_RESUME_SEL_IN; // RULE3
         if (REQ_RESUME_SEL_IN) begin
            next_legacy_ip = REQ_RESUME_IP_IN[31:0];
         end
      end else if ((do_jmp || do_br) && transition_disable) begin
         next_fault = FLT_TRANSITION_DISABLED; // RULE10
      end else if (do_jmp && fp_sync) begin
         next_fault = FLT_LEGACY_FP; // RULE15
      end else if (do_jmp) begin
         next_redirect = 1'b1;
         next_target   = {32'h00000000, tgt.jmp_target}; // RULE12 RULE13 RULE14
         next_select   = 1'b0;
      end else if (do_br) begin
         // mode switches; the fault is raised on the first legacy instruction
         next_redirect  = 1'b1;
         next_target    = {32'h00000000, tgt.br_target}; // RULE17
         next_legacy_ip = tgt.legacy_ip; // RULE17
         next_select    = 1'b1;
         if (tgt.limit_fail || pv_sync) begin
            next_fault = FLT_GENERAL_PROTECTION; // RULE18
         end
      end else if (instr_set_select && sa_sync) begin
         next_fault = FLT_INTERCEPT; // RULE8
      end
   end

   // mode selector and pointer move together, one edge after the request
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         instr_set_select     <= 1'b0;
         last_target          <= 64'h0000000000000000;
         legacy_instr_pointer <= 32'h00000000;
         REDIRECT_OUT         <= 1'b0;
      end else begin
         instr_set_select     <= next_select; // RULE1 RULE23
         last_target          <= next_target; // RULE23
         legacy_instr_pointer <= next_legacy_ip;
         REDIRECT_OUT         <= next_redirect; // RULE23
      end
   end

   // fault reporting, error code zero for protection faults
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         FAULT_OUT      <= 1'b0;
         FAULT_KIND_OUT <= FLT_NONE;
         FAULT_CODE_OUT <= 16'h0000;
         last_fault     <= FLT_NONE;
      end else begin
         FAULT_OUT      <= (next_fault != FLT_NONE);
         FAULT_KIND_OUT <= next_fault;
         FAULT_CODE_OUT <= `GP_ERR_CODE; // RULE18
         if (next_fault != FLT_NONE) begin
            last_fault <= next_fault;
         end
      end
   end

   // ahb address phase capture; zero wait states
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 8'h00;
      end else begin
         dp_valid <= addr_phase(HSEL_IN, HTRANS_IN, HREADY_IN);
         dp_write <= HWRITE_IN;
         dp_addr  <= HADDR_IN;
      end
   end

   // software-writable registers; no transfer touches the privilege level
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         transition_disable <= 1'b0;
         priv_level         <= 2'h0;
         code_segment_base  <= 32'h00000000;
         cs_limit           <= `CS_LIMIT_RESET;
      end else if (dp_valid && dp_write) begin
         unique case (dp_addr)
            `OFF_CTRL: begin
               transition_disable <= HWDATA_IN[`CTRL_DISABLE_BIT]; // RULE10
               priv_level         <= HWDATA_IN[`CTRL_CPL_LSB +: 2]; // RULE16
            end
            `OFF_CS_BASE:  code_segment_base <= HWDATA_IN;
            `OFF_CS_LIMIT: cs_limit          <= HWDATA_IN;
            default: ;  // read-only or unmapped: write ignored
         endcase
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      HRDATA_OUT = 32'h00000000;
      if (dp_valid && !dp_write) begin
         unique case (dp_addr)
            `OFF_CTRL:      HRDATA_OUT = {29'h0, priv_level, transition_disable};
            `OFF_STATUS:    HRDATA_OUT = {25'h0, priv_level, HIDE_NATIVE_OUT, SEG_ENABLE_OUT,
                                          FORCE_LE_OUT, transition_disable, instr_set_select};
            `OFF_CS_BASE:   HRDATA_OUT = code_segment_base;
            `OFF_CS_LIMIT:  HRDATA_OUT = cs_limit;
            `OFF_TGT_LO:    HRDATA_OUT = last_target[31:0];
            `OFF_TGT_HI:    HRDATA_OUT = last_target[63:32];
            `OFF_LEGACY_IP: HRDATA_OUT = legacy_instr_pointer;
            `OFF_FAULT:     HRDATA_OUT = {29'h0, last_fault};
            default:        HRDATA_OUT = 32'h00000000;
         endcase
      end
   end

   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT     = 1'b0;

   // mode-dependent address, endian and visibility controls
   assign INSTR_SET_SELECT_OUT     = instr_set_select; // RULE1
   assign SEG_ENABLE_OUT           = instr_set_select; // RULE4
   assign ADDR_LIMIT4G_OUT         = instr_set_select; // RULE5 RULE6
   assign FORCE_LE_OUT             = instr_set_select; // RULE7
   assign HIDE_NATIVE_OUT          = instr_set_select; // RULE9
   assign PRIV_LEVEL_OUT           = priv_level; // RULE16
   assign TARGET_IP_OUT            = last_target;
   assign LEGACY_INSTR_POINTER_OUT = legacy_instr_pointer;
   // stores into the legacy stream are not snooped, so no flush path exists here // RULE21
endmodule
`default_nettype wire

// >>> inc/isa_mode_defines.svh
// constants for the instruction-set mode switch block
`ifndef ISA_MODE_DEFINES_SVH
`define ISA_MODE_DEFINES_SVH
// register byte offsets (word aligned)
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_CS_BASE     8'h08
`define OFF_CS_LIMIT    8'h0C
`define OFF_TGT_LO      8'h10
`define OFF_TGT_HI      8'h14
`define OFF_LEGACY_IP   8'h18
`define OFF_FAULT       8'h1C
// control register field positions
`define CTRL_DISABLE_BIT 0
`define CTRL_CPL_LSB     1
// status register field positions
`define STAT_SELECT_BIT  0
`define STAT_DISABLE_BIT 1
`define STAT_LE_BIT      2
`define STAT_SEG_BIT     3
`define STAT_HIDE_BIT    4
`define STAT_CPL_LSB     5
// reset values
`define CS_LIMIT_RESET   32'hFFFFFFFF
// alignment mask for native jump targets (16 bytes)
`define ALIGN_MASK       32'hFFFFFFF0
// general protection fault error code
`define GP_ERR_CODE      16'h0000
`endif

// >>> inc/isa_mode_pkg.sv
// types for the instruction-set mode switch block
package isa_mode_pkg;
   // request kinds presented by the front end
   typedef enum logic [2:0] {
      REQ_NONE,
      REQ_JMP_NATIVE_ABS,
      REQ_JMP_NATIVE_REG,
      REQ_BR_LEGACY,
      REQ_RETURN_INTR,
      REQ_INTERRUPT
   } req_kind_t;
   // fault kinds reported back
   typedef enum logic [2:0] {
      FLT_NONE,
      FLT_TRANSITION_DISABLED,
      FLT_LEGACY_FP,
      FLT_GENERAL_PROTECTION,
      FLT_INTERCEPT
   } fault_kind_t;
endpackage

// >>> inc/target_if.sv
// interface carrying a computed target from the calculator to the controller
`timescale 1ns/1ps
`default_nettype none
interface target_if;
   logic [31:0] jmp_target;   // aligned native jump target, low half
   logic [31:0] legacy_ip;    // legacy pointer for branch-to-legacy
   logic [31:0] br_target;    // native pointer low half for branch-to-legacy
   logic        limit_fail;   // legacy target beyond segment limit
   modport calc (output jmp_target, output legacy_ip, output br_target, output limit_fail);
   modport ctrl (input jmp_target, input legacy_ip, input br_target, input limit_fail);
endinterface
`default_nettype wire

// >>> design/target_calc.sv
// combinational target-pointer arithmetic for both transfer instructions
`timescale 1ns/1ps
`default_nettype none
`include "isa_mode_defines.svh"
module target_calc (
   input  wire logic        use_reg_in,     // register-indirect form of native jump
   input  wire logic        opsize32_in,    // operand is 32 bits, else 16
   input  wire logic [31:0] disp_in,        // displacement for absolute form
   input  wire logic [31:0] reg_val_in,     // register value for indirect form
   input  wire logic [31:0] src_branch_in,  // low half of the source branch register
   input  wire logic [31:0] cs_base_in,     // code segment base
   input  wire logic [31:0] cs_limit_in,    // code segment limit
   target_if.calc           tgt
);
   import isa_mode_pkg::*;
   logic [31:0] operand;   // chosen, size-trimmed operand
   logic [31:0] sum;       // operand plus code segment base
   // pick the operand and drop the upper half when the operand is 16 bits
   always_comb begin
      operand = use_reg_in ? reg_val_in : disp_in; // RULE12 RULE13
      if (!opsize32_in) begin
         operand = {16'h0000, operand[15:0]}; // RULE13
      end
   end
   // 32-bit sum wraps, so the target can never leave the low 4G bytes
   assign sum              = operand + cs_base_in; // RULE12 RULE13
   assign tgt.jmp_target   = sum & `ALIGN_MASK; // RULE14
   assign tgt.br_target    = src_branch_in; // RULE17
   assign tgt.legacy_ip    = src_branch_in - cs_base_in; // RULE17
   assign tgt.limit_fail   = (src_branch_in - cs_base_in) > cs_limit_in; // RULE18
endmodule
`default_nettype wire

// >>> test/isa_mode_chk_sva.sv
// concurrent checks on the ports of the instruction-set mode switch
`timescale 1ns/1ps
`default_nettype none
module isa_mode_chk
   import isa_mode_pkg::*;
(
   input wire logic                      CLK_IN,
   input wire logic                      RST_B_IN,
   input wire logic [1:0]                HTRANS_IN,
   input wire logic                      REQ_VALID_IN,
   input wire isa_mode_pkg::req_kind_t   REQ_KIND_IN,
   input wire logic [31:0]               REQ_SRC_BRANCH_IN,
   input wire logic                      REQ_RESUME_SEL_IN,
   input wire logic [63:0]               REQ_VECTOR_IN,
   input wire logic                      SYS_ACCESS_IN,
   input wire logic                      INSTR_SET_SELECT_OUT,
   input wire logic                      REDIRECT_OUT,
   input wire logic [63:0]               TARGET_IP_OUT,
   input wire logic                      FAULT_OUT,
   input wire isa_mode_pkg::fault_kind_t FAULT_KIND_OUT,
   input wire logic [15:0]               FAULT_CODE_OUT,
   input wire logic                      SEG_ENABLE_OUT,
   input wire logic                      ADDR_LIMIT4G_OUT,
   input wire logic                      FORCE_LE_OUT,
   input wire logic                      HIDE_NATIVE_OUT,
   input wire logic [1:0]                PRIV_LEVEL_OUT,
   input wire logic                      HREADYOUT_OUT,
   input wire logic                      HRESP_OUT
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // legacy-only limits follow the selector exactly
   property p_views; {SEG_ENABLE_OUT, ADDR_LIMIT4G_OUT, FORCE_LE_OUT, HIDE_NATIVE_OUT} == {4{INSTR_SET_SELECT_OUT}}; endproperty
   a_views: assert property (p_views) else $error("mode views differ from selector");
   // interruption always lands in native mode at the vector, disable bit or not
   property p_intr; REQ_VALID_IN && REQ_KIND_IN == REQ_INTERRUPT |=>
      REDIRECT_OUT && !INSTR_SET_SELECT_OUT && TARGET_IP_OUT == $past(REQ_VECTOR_IN); endproperty
   a_intr: assert property (p_intr) else $error("interruption did not enter native mode");
   property p_ret; REQ_VALID_IN && REQ_KIND_IN == REQ_RETURN_INTR |=>
      REDIRECT_OUT && INSTR_SET_SELECT_OUT == $past(REQ_RESUME_SEL_IN); endproperty
   a_ret: assert property (p_ret) else $error("return did not restore selector");
   // a taken native jump is aligned and in the low 4G; a refused one leaves the mode alone
   property p_jmp; REQ_VALID_IN && REQ_KIND_IN inside {REQ_JMP_NATIVE_ABS, REQ_JMP_NATIVE_REG} && INSTR_SET_SELECT_OUT |=>
      (FAULT_OUT ? (!REDIRECT_OUT && INSTR_SET_SELECT_OUT) : (REDIRECT_OUT && !INSTR_SET_SELECT_OUT &&
      TARGET_IP_OUT[63:32] == 32'h0 && TARGET_IP_OUT[3:0] == 4'h0)); endproperty
   a_jmp: assert property (p_jmp) else $error("native jump target or fault wrong");
   property p_br; REQ_VALID_IN && REQ_KIND_IN == REQ_BR_LEGACY && !INSTR_SET_SELECT_OUT |=>
      (REDIRECT_OUT ? (INSTR_SET_SELECT_OUT && TARGET_IP_OUT == {32'h0, $past(REQ_SRC_BRANCH_IN)})
      : (FAULT_OUT && !INSTR_SET_SELECT_OUT)); endproperty
   a_br: assert property (p_br) else $error("legacy branch target wrong");
   property p_gp; FAULT_OUT && FAULT_KIND_OUT == FLT_GENERAL_PROTECTION |->
      REDIRECT_OUT && INSTR_SET_SELECT_OUT && FAULT_CODE_OUT == 16'h0000; endproperty
   a_gp: assert property (p_gp) else $error("protection fault not on legacy target");
   // selector never moves without the pointer load beside it
   property p_sync; $changed(INSTR_SET_SELECT_OUT) |-> REDIRECT_OUT; endproperty
   a_sync: assert property (p_sync) else $error("selector changed without redirect");
   // with no bus traffic nearby, a transfer keeps the privilege level
   property p_priv; REQ_VALID_IN && !HTRANS_IN[1] && !$past(HTRANS_IN[1], 1) && !$past(HTRANS_IN[1], 2) |=>
      $stable(PRIV_LEVEL_OUT) ##1 $stable(PRIV_LEVEL_OUT); endproperty
   a_priv: assert property (p_priv) else $error("transfer changed privilege level");
   // two synchroniser stages, then the fault register
   property p_icpt; $rose(SYS_ACCESS_IN) && INSTR_SET_SELECT_OUT ##1 (INSTR_SET_SELECT_OUT && SYS_ACCESS_IN &&
      !REQ_VALID_IN)[*3] |-> ##[0:2] (FAULT_OUT && FAULT_KIND_OUT == FLT_INTERCEPT); endproperty
   a_icpt: assert property (p_icpt) else $error("system access not intercepted");
   property p_bus; HREADYOUT_OUT && !HRESP_OUT; endproperty
   a_bus: assert property (p_bus) else $error("bus slave stalled or erred");
endmodule
bind isa_mode_switch isa_mode_chk u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .HTRANS_IN(HTRANS_IN),
   .REQ_VALID_IN(REQ_VALID_IN), .REQ_KIND_IN(REQ_KIND_IN), .REQ_SRC_BRANCH_IN(REQ_SRC_BRANCH_IN),
   .REQ_RESUME_SEL_IN(REQ_RESUME_SEL_IN), .REQ_VECTOR_IN(REQ_VECTOR_IN), .SYS_ACCESS_IN(SYS_ACCESS_IN),
   .INSTR_SET_SELECT_OUT(INSTR_SET_SELECT_OUT), .REDIRECT_OUT(REDIRECT_OUT), .TARGET_IP_OUT(TARGET_IP_OUT),
   .FAULT_OUT(FAULT_OUT), .FAULT_KIND_OUT(FAULT_KIND_OUT), .FAULT_CODE_OUT(FAULT_CODE_OUT),
   .SEG_ENABLE_OUT(SEG_ENABLE_OUT), .ADDR_LIMIT4G_OUT(ADDR_LIMIT4G_OUT), .FORCE_LE_OUT(FORCE_LE_OUT),
   .HIDE_NATIVE_OUT(HIDE_NATIVE_OUT), .PRIV_LEVEL_OUT(PRIV_LEVEL_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
   .HRESP_OUT(HRESP_OUT));
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the instruction-set mode switch
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import isa_mode_pkg::*;
   logic        clk, rst_b, hwrite, req_valid, opsize32, fp_pend, sys_acc, hready, resume_sel, priv_fail; // driven by the bench, except hready, which loops back from HREADYOUT_OUT
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, operand, src, hrdata, lip, rd;
   logic [63:0] resume_ip, vector, tip;
   req_kind_t   kind;
   fault_kind_t fkind;
   logic        hresp, sel, redir, fault, seg, lim, le, hide;     // observed outputs
   logic [15:0] fcode;
   logic [1:0]  priv;
   int          fails, checks_done;
   // hsel and hsize are the only tied inputs
   isa_mode_switch uut (.CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
      .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .REQ_VALID_IN(req_valid), .REQ_KIND_IN(kind),
      .REQ_OPSIZE32_IN(opsize32), .REQ_OPERAND_IN(operand), .REQ_SRC_BRANCH_IN(src), .REQ_RESUME_IP_IN(resume_ip),
      .REQ_RESUME_SEL_IN(resume_sel), .REQ_VECTOR_IN(vector), .FP_PENDING_IN(fp_pend), .CS_PRIV_FAIL_IN(priv_fail),
      .SYS_ACCESS_IN(sys_acc), .INSTR_SET_SELECT_OUT(sel), .REDIRECT_OUT(redir), .TARGET_IP_OUT(tip),
      .LEGACY_INSTR_POINTER_OUT(lip), .FAULT_OUT(fault), .FAULT_KIND_OUT(fkind), .FAULT_CODE_OUT(fcode),
      .SEG_ENABLE_OUT(seg), .ADDR_LIMIT4G_OUT(lim), .FORCE_LE_OUT(le), .HIDE_NATIVE_OUT(hide), .PRIV_LEVEL_OUT(priv));
   // 40 MHz core clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // four-state compare so an unknown never matches
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask
   // one single-word ahb transfer; read data taken at the closing ready edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      // address phase holds until ready, then the data phase holds until ready
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (hready === 1'b1 && htrans == 2'b00) break;
         if (hready === 1'b1) begin
            htrans <= 2'b00;
            hwdata <= wd;
         end
      end
      rd = hrdata;
      if (n == 40) begin
         fails++;
         finish_test();
      end
   endtask
   // one-cycle request strobe; returns on the edge that closes the answer cycle
   task automatic req(input req_kind_t k, input logic [31:0] op, input logic [31:0] s, input logic o32);
      @(posedge clk);
      req_valid <= 1'b1;
      kind <= k;
      operand <= op;
      src <= s;
      opsize32 <= o32;
      @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic outs(input logic r, input logic f, input fault_kind_t fk, input logic s, input logic [63:0] t);
      chk("redirect", r, redir);
      chk("fault", f, fault);
      if (f) chk("fault kind", fk, fkind);
      chk("selector", s, sel);
      chk("mode views", {4{s}}, {seg, lim, le, hide});
      if (r) chk("target", t, tip);
   endtask
   task automatic t_reset;
      outs(1'b0, 1'b0, FLT_NONE, 1'b0, 64'h0);
      bus(1'b1, 8'h04, 32'hFFFFFFFF);
      bus(1'b0, 8'h04, 32'h0);
      chk("status", 32'h00000000, rd);
      bus(1'b0, 8'h0C, 32'h0);
      chk("segment limit", 32'hFFFFFFFF, rd);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h00000000, rd);
      $display("test reset done");
   endtask
   task automatic t_transfers;
      bus(1'b1, 8'h08, 32'h00001000);
      bus(1'b1, 8'h00, 32'h00000004);
      req(REQ_BR_LEGACY, 32'h0, 32'h00012345, 1'b1);
      outs(1'b1, 1'b0, FLT_NONE, 1'b1, 64'h12345);
      chk("legacy pointer", 32'h00011345, lip);
      chk("privilege", 2'b10, priv);
      req(REQ_JMP_NATIVE_ABS, 32'hFFFFF01B, 32'h0, 1'b1);
      outs(1'b1, 1'b0, FLT_NONE, 1'b0, 64'h10);
      req(REQ_BR_LEGACY, 32'h0, 32'h00002000, 1'b1);
      req(REQ_JMP_NATIVE_REG, 32'hABCD1234, 32'h0, 1'b0);
      outs(1'b1, 1'b0, FLT_NONE, 1'b0, 64'h2230);
      chk("privilege", 2'b10, priv);
      $display("test transfers done");
   endtask
   task automatic t_faults;
      req(REQ_BR_LEGACY, 32'h0, 32'h00003000, 1'b1);
      fp_pend <= 1'b1;
      repeat (3) @(posedge clk);
      req(REQ_JMP_NATIVE_ABS, 32'h40, 32'h0, 1'b1);
      outs(1'b0, 1'b1, FLT_LEGACY_FP, 1'b1, 64'h0);
      fp_pend <= 1'b0;
      bus(1'b1, 8'h00, 32'h00000005);
      req(REQ_JMP_NATIVE_ABS, 32'h40, 32'h0, 1'b1);
      outs(1'b0, 1'b1, FLT_TRANSITION_DISABLED, 1'b1, 64'h0);
      req(REQ_INTERRUPT, 32'h0, 32'h0, 1'b1);
      outs(1'b1, 1'b0, FLT_NONE, 1'b0, vector);
      req(REQ_BR_LEGACY, 32'h0, 32'h00004000, 1'b1);
      outs(1'b0, 1'b1, FLT_TRANSITION_DISABLED, 1'b0, 64'h0);
      req(REQ_RETURN_INTR, 32'h0, 32'h0, 1'b1);
      outs(1'b1, 1'b0, FLT_NONE, 1'b1, resume_ip);
      bus(1'b0, 8'h04, 32'h0);
      chk("status", 32'h0000005F, rd);
      bus(1'b1, 8'h00, 32'h00000004);
      sys_acc <= 1'b1;
      for (int n = 0; n < 8 && fault !== 1'b1; n++) @(posedge clk);
      chk("intercept", 1'b1, fault);
      chk("intercept kind", FLT_INTERCEPT, fkind);
      sys_acc <= 1'b0;
      repeat (3) @(posedge clk);
      req(REQ_INTERRUPT, 32'h0, 32'h0, 1'b1);
      bus(1'b1, 8'h0C, 32'h00000100);
      req(REQ_BR_LEGACY, 32'h0, 32'h00001200, 1'b1);
      outs(1'b1, 1'b1, FLT_GENERAL_PROTECTION, 1'b1, 64'h1200);
      chk("fault code", 16'h0000, fcode);
      priv_fail <= 1'b1;
      req(REQ_INTERRUPT, 32'h0, 32'h0, 1'b1);
      req(REQ_BR_LEGACY, 32'h0, 32'h00001080, 1'b1);
      outs(1'b1, 1'b1, FLT_GENERAL_PROTECTION, 1'b1, 64'h1080);
      $display("test faults done");
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end
   initial begin
      rst_b = 1'b0;
      {hwrite, req_valid, opsize32, fp_pend, sys_acc, priv_fail, resume_sel} = 7'b0000001;
      {haddr, htrans, hwdata, operand, src} = '0;
      kind = REQ_NONE;
      resume_ip = 64'h0000000000045670;
      vector = 64'hFFFF000000000400;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_transfers();
      t_faults();
      finish_test();
   end
endmodule
`default_nettype wire
